// File: hdl/reog_pkg.sv
/*
 Constants, types and timing for the rotary encoder output generator.
 Assumes a single 25 MHz clock and a 10-bit angle sampled on that clock.
*/
// Function
// [R01] PWM frame is always 1025 microseconds
// [R02] High time is position plus one microsecond
// [R03] Receiver scales high time by measured period
// [R04] Receiver measures both high and low time
// [R05] A leads B clockwise, B leads counterclockwise
// [R06] Step resolution 64 to 512, LSB drives pulse
// [R07] Direction 1 clockwise, refreshed every LSB change
// [R08] Index at zero, one to three steps wide
// [R09] Resolution and index width are user selectable
// [R10] Reversal holds outputs until moved back 2 LSB
// [R11] Hysteresis counted in full 10-bit steps
// [R12] Same direction: every position change shown immediately
// [R13] Unlock input active low, tie low if unused
// [R14] Outputs valid within 500 ns of unlock
// [R15] Direction valid within 500 ns of pulse edge
// [R16] Unlock high at power-up holds A, B, index high
// [R17] Angle sampled and outputs refreshed every 96 us
// [R18] Microsecond tick, 1025 ticks, load at frame start
package reog_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS   = 40;
	localparam int unsigned TICK_NS         = 1000;
	localparam int unsigned TICK_CYC        = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned FRAME_US        = 1025;
	localparam int unsigned FRAME_TICKS     = FRAME_US * TICK_NS / TICK_NS;
	localparam int unsigned SAMPLE_US       = 96;
	localparam int unsigned SAMPLE_CYC      = SAMPLE_US * TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned UNLOCK_MAX_NS   = 500;
	localparam int unsigned UNLOCK_MAX_CYC  = UNLOCK_MAX_NS / CLK_PERIOD_NS;
	localparam int unsigned DIR_VALID_NS    = 500;
	localparam int unsigned DIR_VALID_CYC   = DIR_VALID_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////////
	// Position format
	localparam int unsigned ANGLE_W         = 10;
	localparam logic [ANGLE_W-1:0] HYST_LSB = 10'h002;
	localparam logic [ANGLE_W-1:0] POS_ZERO = 10'h000;
	localparam int unsigned SYNC_SETTLE     = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration
	typedef enum logic [1:0]
	{
		REOG_MODE_QUAD    = 2'h1,
		REOG_MODE_STEPDIR = 2'h2
	} reog_mode_e;

	// Resolution code: 0=64, 1=128, 2=256, 3=512
	typedef logic [1:0] reog_res_t;

	typedef struct packed
	{
		reog_mode_e mode;
		reog_res_t  res_sel;
		logic [1:0] index_width;
	} reog_cfg_s;

	typedef struct packed
	{
		logic a_or_pulse;
		logic b_or_dir;
		logic index;
	} reog_inc_s;

	localparam reog_inc_s INC_LOCKED = 3'h7;

	typedef enum logic [2:0]
	{
		ST_SETTLE = 3'h1,
		ST_LOCKED = 3'h2,
		ST_RUN    = 3'h4
	} reog_state_e;

endpackage

// File: hdl/reog_pwm_gen.sv
/*
 Width-modulated absolute position output.
 Assumes i_pos is a stable registered position on the same clock.
*/
`timescale 1ns/1ns
module reog_pwm_gen
	import reog_pkg::*;
#(
	parameter int unsigned TICK_CYCLES  = TICK_CYC,
	parameter int unsigned FRAME_LEN    = FRAME_TICKS,
	parameter int unsigned POS_W        = ANGLE_W
)
(
	input  wire logic             i_clock,
	input  wire logic             i_srst,
	input  wire logic [POS_W-1:0] i_pos,
	output logic                  o_pwm
);

	localparam int unsigned CNT_W = $clog2(FRAME_LEN);
	localparam int unsigned PRE_W = $clog2(TICK_CYCLES);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FRAME_LEN - 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

	// Frame must leave at least one low tick for the largest position
	if (FRAME_LEN <= (2 ** POS_W) || TICK_CYCLES < 2)
	begin : g_bad_cfg
		$error("reog_pwm_gen: frame or tick length cannot serve position width");
	end

	logic [PRE_W-1:0] pre_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] pos_q;
	logic             tick;

	assign tick = (pre_q == PRE_LAST);

	////////////////////////////////////////////////////////////////////////////////
	// Microsecond tick
	always_ff @(posedge i_clock)
	begin
		if (i_srst || tick)
			pre_q <= '0;
		else
			pre_q <= pre_q + 1'b1; // [R18]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frame counter; position taken only at frame start so a frame never tears
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			cnt_q <= '0;
			pos_q <= '0;
		end
		else if (tick)
		begin
			if (cnt_q == CNT_LAST)
			begin
				cnt_q <= '0; // [R01]
				pos_q <= CNT_W'(i_pos); // [R18]
			end
			else
				cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			o_pwm <= 1'b0;
		else
			o_pwm <= (cnt_q <= pos_q); // [R02]
	end

endmodule // reog_pwm_gen

// File: hdl/reog_top.sv
/*
 Output generator of a magnetic rotary encoder: sampling, hysteresis,
 quadrature or step/direction outputs, index, power-up lock and PWM.
 Assumes i_angle comes from the sensor core on i_clock; the unlock pin is
 asynchronous and is synchronised here.
*/
`timescale 1ns/1ns
module reog_top
	import reog_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC
)
(
	input  wire logic               i_clock,
	input  wire logic               i_srst,
	input  wire logic [ANGLE_W-1:0] i_angle,
	input  wire reog_cfg_s          i_cfg,
	input  wire logic               i_output_unlock_n,
	output logic                    o_pwm,
	output logic                    o_inc_a,
	output logic                    o_inc_b,
	output logic                    o_index,
	output logic                    o_locked
);

	localparam int unsigned SCNT_W = $clog2(SAMPLE_CYCLES);
	localparam logic [SCNT_W-1:0] SCNT_LAST = SCNT_W'(SAMPLE_CYCLES - 1);
	localparam logic [1:0] SETTLE_LAST = 2'(SYNC_SETTLE - 1);

	if (SAMPLE_CYCLES < 2 || ANGLE_W != 10)
	begin : g_bad_cfg
		$error("reog_top: sample period or angle width unsupported");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decoding shared by pulse and index logic

	// Position at the programmed resolution (64..512)
	function automatic logic [ANGLE_W-1:0] coarse_pos(input logic [ANGLE_W-1:0] pos, input reog_res_t res);
		logic [ANGLE_W-1:0] r;
		r = '0;
		case (res)
			2'h0:    r = pos >> 4;
			2'h1:    r = pos >> 3;
			2'h2:    r = pos >> 2;
			default: r = pos >> 1;
		endcase
		return r;
	endfunction

	// Index width in steps, zero treated as the default of one
	function automatic logic [ANGLE_W-1:0] index_steps(input logic [1:0] w);
		logic [ANGLE_W-1:0] r;
		r = '0;
		if (w == 2'h0)
			r = 10'h001;
		else
			r = ANGLE_W'(w);
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Unlock pin synchroniser: a level counts once stages two and three agree
	logic sync1_q;
	logic sync2_q;
	logic sync3_q;
	logic unlock_lvl_q;

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			sync3_q <= 1'b1;
		end
		else
		begin
			sync1_q <= i_output_unlock_n;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// Defaults high, like the pin's pull-up
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			unlock_lvl_q <= 1'b1;
		else if (sync2_q == sync3_q)
			unlock_lvl_q <= sync3_q; // [R13]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power-up lock
	reog_state_e state_q;
	logic [1:0]  settle_q;

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			settle_q <= '0;
		else if (state_q == ST_SETTLE && settle_q != SETTLE_LAST)
			settle_q <= settle_q + 1'b1;
	end

	// Pin level is caught three cycles after release, while unlock_lvl_q still holds its reset high
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			state_q <= ST_SETTLE;
		else
		begin
			case (state_q)
				ST_SETTLE:
				begin
					if (settle_q == SETTLE_LAST)
					begin
						if (unlock_lvl_q)
							state_q <= ST_LOCKED; // [R16]
						else
							state_q <= ST_RUN;
					end
				end
				ST_LOCKED:
				begin
					if (!unlock_lvl_q)
						state_q <= ST_RUN; // [R14]
				end
				ST_RUN:
					state_q <= ST_RUN;
				default:
					state_q <= ST_SETTLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sampling timebase
	logic [SCNT_W-1:0]  smp_cnt_q;
	logic               smp_stb;
	logic [ANGLE_W-1:0] smp_q;
	logic               smp_seen_q;

	assign smp_stb = (smp_cnt_q == SCNT_LAST);

	always_ff @(posedge i_clock)
	begin
		if (i_srst || smp_stb)
			smp_cnt_q <= '0;
		else
			smp_cnt_q <= smp_cnt_q + 1'b1; // [R17]
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			smp_q <= POS_ZERO;
		else if (smp_stb)
			smp_q <= i_angle; // [R17]
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			smp_seen_q <= 1'b0;
		else if (smp_stb)
			smp_seen_q <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Hysteresis on direction reversal, always in full 10-bit steps
	logic [ANGLE_W-1:0] trk_q;
	logic               trk_cw_q;
	logic [ANGLE_W-1:0] diff;
	logic [ANGLE_W-1:0] mag;
	logic               fwd;
	logic               bwd;
	logic               accept;

	always_comb
	begin
		diff   = smp_q - trk_q;
		fwd    = (diff != POS_ZERO) && !diff[ANGLE_W-1];
		bwd    = diff[ANGLE_W-1];
		mag    = bwd ? (POS_ZERO - diff) : diff; // [R11]
		accept = (fwd && trk_cw_q) || (bwd && !trk_cw_q); // [R12]
		if ((fwd || bwd) && mag >= HYST_LSB)
			accept = 1'b1; // [R10]
	end

	// Runs one cycle after each sample is latched
	logic eval_q;

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			eval_q <= 1'b0;
		else
			eval_q <= smp_stb;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			trk_q    <= POS_ZERO;
			trk_cw_q <= 1'b1;
		end
		else if (eval_q && accept)
		begin
			trk_q    <= smp_q; // [R10] [R12]
			trk_cw_q <= fwd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output position walks one fine step per clock toward the tracked value,
	// so a large jump between samples still yields every edge in order
	logic [ANGLE_W-1:0] opos_q;
	logic               odir_q;
	logic [ANGLE_W-1:0] walk;

	assign walk = trk_q - opos_q;

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			opos_q <= POS_ZERO;
			odir_q <= 1'b1;
		end
		else if (walk != POS_ZERO)
		begin
			if (walk[ANGLE_W-1])
			begin
				opos_q <= opos_q - 1'b1;
				odir_q <= 1'b0; // [R07]
			end
			else
			begin
				opos_q <= opos_q + 1'b1;
				odir_q <= 1'b1; // [R07]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Incremental pin encoding
	reog_inc_s          inc_d;
	reog_inc_s          inc_q;
	logic [ANGLE_W-1:0] cpos;

	always_comb
	begin
		cpos        = coarse_pos(opos_q, i_cfg.res_sel); // [R06] [R09]
		inc_d.index = (cpos < index_steps(i_cfg.index_width)); // [R08] [R09]
		case (i_cfg.mode)
			REOG_MODE_STEPDIR:
			begin
				inc_d.a_or_pulse = cpos[0]; // [R06]
				// Direction changes with the first fine step of a reversal, never after the pulse edge
				inc_d.b_or_dir   = odir_q; // [R07] [R15]
			end
			default:
			begin
				inc_d.a_or_pulse = cpos[1] ^ cpos[0]; // [R05]
				inc_d.b_or_dir   = cpos[1]; // [R05]
			end
		endcase
		if (state_q != ST_RUN || !smp_seen_q)
			inc_d = INC_LOCKED; // [R16]
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			inc_q <= INC_LOCKED;
		else
			inc_q <= inc_d; // [R14]
	end

	assign o_inc_a = inc_q.a_or_pulse;
	assign o_inc_b = inc_q.b_or_dir;
	assign o_index = inc_q.index;

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			o_locked <= 1'b1;
		else
			o_locked <= (state_q != ST_RUN) || !smp_seen_q; // [R16]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Absolute PWM output, free of hysteresis
	reog_pwm_gen #(
		.TICK_CYCLES (TICK_CYC),
		.FRAME_LEN   (FRAME_TICKS),
		.POS_W       (ANGLE_W)
	) u_pwm (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.i_pos   (smp_q),
		.o_pwm   (o_pwm)
	);

endmodule // reog_top

// File: tb/reog_chk.sv
/*
 Port checker for reog_top, attached by the bind at the foot.
 Assumes one clock and the synchronous reset of the top module.
*/
`timescale 1ns/1ns
module reog_chk
	import reog_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC
)
(
	input  wire logic               i_clock,
	input  wire logic               i_srst,
	input  wire logic [ANGLE_W-1:0] i_angle,
	input  wire reog_cfg_s          i_cfg,
	input  wire logic               i_output_unlock_n,
	input  wire logic               o_pwm,
	input  wire logic               o_inc_a,
	input  wire logic               o_inc_b,
	input  wire logic               o_index,
	input  wire logic               o_locked
);
	localparam int HI_MAX = 1024 * TICK_CYC;
	logic [15:0] hi_q, per_q, cyc_q;
	logic        pwm_q, seen_q;
	wire         quad  = i_cfg.mode != REOG_MODE_STEPDIR;
	wire         armed = o_locked && 32'(cyc_q) > SAMPLE_CYCLES + 4;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);
	////////////////////////////////////////////////////////////////////////////////
	// High-time and frame counters; uptime saturates so it cannot wrap
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			hi_q   <= '0;
			per_q  <= '0;
			cyc_q  <= '0;
			pwm_q  <= 1'h0;
			seen_q <= 1'h0;
		end
		else
		begin
			hi_q   <= o_pwm ? hi_q + 16'h1 : 16'h0;
			per_q  <= (o_pwm && !pwm_q) ? 16'h1 : per_q + 16'h1;
			cyc_q  <= (&cyc_q) ? cyc_q : cyc_q + 16'h1;
			pwm_q  <= o_pwm;
			seen_q <= seen_q | (o_pwm && !pwm_q);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_reset_state: assert property ($fell(i_srst) |-> o_locked && !o_pwm && o_inc_a && o_inc_b && o_index)
		else $error("outputs not at reset values");
	a_pwm_high: assert property ($fell(o_pwm) |-> hi_q % TICK_CYC == 0 && hi_q >= TICK_CYC && hi_q <= HI_MAX)
		else $error("pwm high time off the tick grid");
	a_pwm_frame: assert property (o_pwm && !pwm_q && seen_q |-> per_q == FRAME_TICKS * TICK_CYC)
		else $error("pwm frame length wrong");
	a_lock_high: assert property (o_locked |-> o_inc_a && o_inc_b && o_index)
		else $error("locked outputs not high");
	a_unlock_sticky: assert property (!o_locked |=> !o_locked)
		else $error("lock returned without reset");
	a_unlock_fast: assert property ((armed && $fell(i_output_unlock_n) ##1 !i_output_unlock_n [*4]) |-> ##[0:8] !o_locked)
		else $error("unlock too slow");
	a_quad_gray: assert property (quad && !o_locked && !$past(o_locked, 2) |-> !($changed(o_inc_a) && $changed(o_inc_b)))
		else $error("both channels moved at once");
	a_index_zero: assert property (quad && i_cfg.index_width <= 2'h1 && o_index && !o_locked |-> !o_inc_a && !o_inc_b)
		else $error("index away from zero state");
	c_unlock: cover property ($fell(o_locked));
	c_pwm: cover property ($fell(o_pwm) && seen_q);
	c_index: cover property ($rose(o_index) && !o_locked);
endmodule // reog_chk

bind reog_top reog_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (.i_clock(i_clock), .i_srst(i_srst),
	.i_angle(i_angle), .i_cfg(i_cfg), .i_output_unlock_n(i_output_unlock_n), .o_pwm(o_pwm),
	.o_inc_a(o_inc_a), .o_inc_b(o_inc_b), .o_index(o_index), .o_locked(o_locked));

// File: tb/reog_partner.sv
/*
 Receiving counter logic: decodes incremental pins and the pwm line.
 Assumes the encoder pins are registered on the same clock.
*/
`timescale 1ns/1ns
module reog_partner
	import reog_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_srst,
	input  wire reog_mode_e i_mode,
	input  wire logic       i_a,
	input  wire logic       i_b,
	input  wire logic       i_pwm,
	output int              o_count,
	output int              o_pwm_pos,
	output int              o_pwm_hi,
	output int              o_frames
);
	logic [1:0] g_q;
	logic       a_q, pwm_q;
	int         hi, run;
	wire  [1:0] g = {i_b, i_a ^ i_b};
	always @(posedge i_clock)
	begin
		if (i_srst)
		begin
			o_count  <= 0;
			o_frames <= 0;
		end
		else
		begin
			if (i_mode == REOG_MODE_STEPDIR)
				o_count <= o_count + ((i_a != a_q) ? (i_b ? 1 : -1) : 0);
			else if (g - g_q == 2'h1)
				o_count <= o_count + 1;
			else if (g_q - g == 2'h1)
				o_count <= o_count - 1;
			// Ratio of high time to measured period, immune to frame drift
			if (i_pwm && !pwm_q)
			begin
				if (o_frames > 0)
					o_pwm_pos <= hi * int'(FRAME_TICKS) / run - 1;
				o_pwm_hi <= hi;
				o_frames <= o_frames + 1;
			end
		end
		hi    <= (i_pwm && !pwm_q) ? 1 : hi + int'(i_pwm);
		run   <= (i_pwm && !pwm_q) ? 1 : run + 1;
		g_q   <= g;
		a_q   <= i_a;
		pwm_q <= i_pwm;
	end
endmodule // reog_partner

// File: tb/reog_top_tb.sv
/*
 Self-checking bench for reog_top with the decoding partner.
 Assumes a short sample interval; the pwm frame keeps full length.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %0d got %0d", nm, e, g); end end
module reog_top_tb
	import reog_pkg::*;
;
	localparam int SC = 16;
	logic               i_clock = 1'h0;
	logic               i_srst = 1'h1;
	logic [ANGLE_W-1:0] i_angle = '0;
	reog_cfg_s          i_cfg = '{REOG_MODE_QUAD, 2'h3, 2'h1};
	logic               i_output_unlock_n = 1'h1;
	logic               o_pwm, o_inc_a, o_inc_b, o_index, o_locked;
	int                 fail_count = 0, compares = 0, cnt, pos, hi, frm, c0;
	always #20 i_clock = ~i_clock;
	reog_top #(.SAMPLE_CYCLES(SC)) i_reog_top (.i_clock(i_clock), .i_srst(i_srst), .i_angle(i_angle),
		.i_cfg(i_cfg), .i_output_unlock_n(i_output_unlock_n), .o_pwm(o_pwm), .o_inc_a(o_inc_a),
		.o_inc_b(o_inc_b), .o_index(o_index), .o_locked(o_locked));
	reog_partner i_reog_partner (.i_clock(i_clock), .i_srst(i_srst), .i_mode(i_cfg.mode), .i_a(o_inc_a),
		.i_b(o_inc_b), .i_pwm(o_pwm), .o_count(cnt), .o_pwm_pos(pos), .o_pwm_hi(hi), .o_frames(frm));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wt(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	// Long enough for four samples plus a 60-step interpolated walk
	task automatic mv(input logic [ANGLE_W-1:0] a);
		@(posedge i_clock);
		i_angle <= a;
		wt(4 * SC + 60);
	endtask
	task automatic rst(input reog_cfg_s c, input logic u);
		@(posedge i_clock);
		i_srst <= 1'h1;
		i_cfg <= c;
		i_output_unlock_n <= u;
		i_angle <= '0;
		wt(5);
		i_srst <= 1'h0;
	endtask
	task summarize;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (80000) @(posedge i_clock);
		fail_count++;
		summarize();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst('{REOG_MODE_QUAD, 2'h3, 2'h1}, 1'h1);
		wt(40);
		`CHK("locked pins", 4'hF, {o_locked, o_inc_a, o_inc_b, o_index})
		i_output_unlock_n <= 1'h0;
		wt(6);
		i_output_unlock_n <= 1'h1;
		wt(12);
		`CHK("unlocked", 1'h0, o_locked)
		`CHK("index at zero", 1'h1, o_index)
		c0 = cnt;
		mv(10'h028);
		`CHK("quad cw", 20, cnt - c0)
		`CHK("index off", 1'h0, o_index)
		mv(10'h027);
		`CHK("quad held", 20, cnt - c0)
		mv(10'h026);
		`CHK("quad back", 19, cnt - c0)
		mv(10'h000);
		`CHK("quad zero", 0, cnt - c0)
		mv(10'h3FC);
		`CHK("quad wrap", -2, cnt - c0)
		// Coarsest resolution and the zero index-width code
		rst('{REOG_MODE_QUAD, 2'h0, 2'h0}, 1'h0);
		wt(4 * SC);
		c0 = cnt;
		mv(10'h040);
		`CHK("quad res 64", 4, cnt - c0)
		mv(10'h00F);
		`CHK("quad res 64 back", 0, cnt - c0)
		`CHK("default index", 1'h1, o_index)
		rst('{REOG_MODE_STEPDIR, 2'h1, 2'h2}, 1'h0);
		wt(4 * SC);
		c0 = cnt;
		mv(10'h018);
		`CHK("steps res 128", 3, cnt - c0)
		`CHK("index two off", 1'h0, o_index)
		mv(10'h00F);
		`CHK("steps res 128 back", 1, cnt - c0)
		`CHK("index two on", 1'h1, o_index)
		// Unlock pin tied low: outputs free once the first sample lands
		rst('{REOG_MODE_STEPDIR, 2'h2, 2'h3}, 1'h0);
		wt(4 * SC);
		`CHK("tied low", 1'h0, o_locked)
		c0 = cnt;
		mv(10'h028);
		`CHK("steps cw", 10, cnt - c0)
		`CHK("dir cw", 1'h1, o_inc_b)
		mv(10'h026);
		`CHK("steps back", 9, cnt - c0)
		`CHK("dir ccw", 1'h0, o_inc_b)
		mv(10'h008);
		`CHK("wide index", 1'h1, o_index)
		mv(10'h00C);
		`CHK("index end", 1'h0, o_index)
		c0 = frm;
		for (int k = 0; k < 60000 && frm < c0 + 2; k++)
			@(posedge i_clock);
		`CHK("pwm high", 13 * TICK_CYC, hi)
		`CHK("pwm pos", 12, pos)
		summarize();
	end
endmodule // reog_top_tb
